// *** src/serial_pkg.sv ***
// shared constants and types for the async serial buffer and mode block
// Function
// - 7-bit LSB-first data lands in bits 0-6
// - 7-bit MSB-first data lands in bits 1-7
// - overrun keeps new character out of buffer
// - receive buffer read-only; both buffers reset FFh
// - writing transmit buffer starts a transmission
// - software never writes transmit buffer while full
// - software waits one base clock before data
// - shifter loads at once, or as the last bit ends
// - load and shift on base clock edges
// - mode register layout, reset value 01h
// - power off gates clock, resets unit asynchronously
// - power off forces output and input high
// - enables synchronised; clearing resets tx/rx circuit
// - parity field selects none, zero, odd, even
// - zero-parity mode never flags parity errors
// - length bit selects seven or eight bits
// - one or two stop bits sent, one checked
// - routing bit steers errors to one interrupt
// - software powers first, disables before power-off
// - enabling reception on low line starts receiving
// - software waits two base clocks before re-enabling
// - software disables before changing frame settings
package serial_pkg;
   localparam logic [15:0] MODE_ADDR       = 16'hFF50;
   localparam logic [15:0] TX_BUF_ADDR     = 16'hFF51;
   localparam logic [15:0] RX_BUF_ADDR     = 16'hFF52;
   localparam logic [15:0] RX_ERR_ADDR     = 16'hFF53;
   localparam logic [15:0] TX_STAT_ADDR    = 16'hFF55;
   localparam logic [7:0]  MODE_RESET      = 8'h01;
   localparam logic [7:0]  BUF_RESET       = 8'hFF;
   localparam int          POWER_BIT       = 7;
   localparam int          TX_EN_BIT       = 6;
   localparam int          RX_EN_BIT       = 5;
   localparam int          PAR_HI_BIT      = 4;
   localparam int          PAR_LO_BIT      = 3;
   localparam int          LEN_BIT         = 2;
   localparam int          STOP_BIT        = 1;
   localparam int          ROUTE_BIT       = 0;
   localparam int          PE_BIT          = 2;
   localparam int          FE_BIT          = 1;
   localparam int          OVE_BIT         = 0;
   localparam int          TXBF_BIT        = 1;
   localparam int          TXSF_BIT        = 0;
   typedef enum logic [1:0] {PAR_NONE, PAR_ZERO, PAR_ODD, PAR_EVEN} parity_t;
   // base clock is the 50 MHz clock divided down; bit time in base clocks
   localparam int          MCLK_HZ         = 50_000_000;
   localparam int          BASE_DIV        = 4;
   localparam int          BIT_BASE_CLKS   = 8;
   localparam int          SAMPLE_POINT    = BIT_BASE_CLKS / 2;
   // software waits, in base clocks, plus one base clock of sync margin
   localparam int          TX_WRITE_WAIT_BASE = 1;
   localparam int          REENABLE_WAIT_BASE = 2;
   localparam int          SYNC_MARGIN_BASE   = 1;
   localparam int          TX_WRITE_WAIT_MCLK = (TX_WRITE_WAIT_BASE + SYNC_MARGIN_BASE) * BASE_DIV;
   localparam int          REENABLE_WAIT_MCLK = (REENABLE_WAIT_BASE + SYNC_MARGIN_BASE) * BASE_DIV;
endpackage

// *** src/serial_cpu_if.sv ***
// register port and interrupt lines between the serial unit and its controller
interface serial_cpu_if;
   logic [15:0] addr;
   logic        wr;
   logic        rd;
   logic [7:0]  wdata;
   logic [7:0]  rdata;
   logic        rx_done_irq;
   logic        rx_error_irq;
   logic        tx_done_irq;
   modport dev  (input addr, wr, rd, wdata, output rdata, rx_done_irq, rx_error_irq, tx_done_irq);
   modport host (output addr, wr, rd, wdata, input rdata, rx_done_irq, rx_error_irq, tx_done_irq);
endinterface

// *** src/serial_device.sv ***
// async serial unit: mode register, data buffers, transmit and receive shifters
module serial_device (
   input  wire logic   mclk,
   input  wire logic   rst_n,
   serial_cpu_if.dev   cpu,
   input  wire logic   serial_in_pin,
   input  wire logic   msb_first,
   output logic        serial_out_pin
);
   localparam int DIV_W = $clog2(serial_pkg::BASE_DIV);
   localparam int SUB_W = $clog2(serial_pkg::BIT_BASE_CLKS);

   typedef enum logic {RX_IDLE, RX_RUN} rx_state_t;

   // first data bit order and framing of one character
   function automatic logic [11:0] build_frame(input logic [7:0] d, input logic [7:0] m, input logic msb);
      logic [7:0]  o;
      logic [11:0] f;
      logic        p;
      int          n;
      o = msb ? {<<{d}} : d;
      f = 12'hFFF;
      f[0] = 1'b0;
      p = 1'b0;
      n = m[serial_pkg::LEN_BIT] ? 8 : 7;
      for (int i = 0; i < 8; i++) begin
         if (i < n) begin
            f[i + 1] = o[i];
            p = p ^ o[i];
         end
      end
      case (serial_pkg::parity_t'(m[serial_pkg::PAR_HI_BIT:serial_pkg::PAR_LO_BIT]))
         serial_pkg::PAR_ZERO: f[n + 1] = 1'b0;
         serial_pkg::PAR_ODD:  f[n + 1] = ~p;
         serial_pkg::PAR_EVEN: f[n + 1] = p;
         default:              f[n + 1] = 1'b1;
      endcase
      return f;
   endfunction

   // number of data bits from the mode register
   function automatic logic [3:0] data_bits(input logic [7:0] m);
      return m[serial_pkg::LEN_BIT] ? 4'h8 : 4'h7;
   endfunction

   logic [7:0]       mode;
   logic [DIV_W-1:0] div_cnt;
   logic             tx_en_s;
   logic             rx_en_s;
   logic             in_meta;
   logic             in_sync;
   logic [7:0]       tx_data_buffer;
   logic             tx_buffer_full_flag;
   logic             tx_busy;
   logic [11:0]      tx_shift_reg;
   logic [3:0]       tx_left;
   logic [SUB_W-1:0] tx_sub;
   rx_state_t        rx_state;
   logic [SUB_W-1:0] rx_sub;
   logic [3:0]       rx_idx;
   logic [7:0]       rx_shift_reg;
   logic             rx_xor;
   logic [7:0]       rx_data_buffer;
   logic             rx_full;
   logic             parity_error_flag;
   logic             framing_error_flag;
   logic             overrun_flag;
   logic [7:0]       rdata_q;

   // register decode
   wire              wr_mode   = cpu.wr && cpu.addr == serial_pkg::MODE_ADDR;
   wire              wr_txbuf  = cpu.wr && cpu.addr == serial_pkg::TX_BUF_ADDR;
   wire              rd_rxbuf  = cpu.rd && cpu.addr == serial_pkg::RX_BUF_ADDR;
   wire              rd_rxerr  = cpu.rd && cpu.addr == serial_pkg::RX_ERR_ADDR;
   wire              power     = mode[serial_pkg::POWER_BIT];
   wire              route     = mode[serial_pkg::ROUTE_BIT];
   wire [1:0]        par_code  = mode[serial_pkg::PAR_HI_BIT:serial_pkg::PAR_LO_BIT];
   wire              has_par   = par_code != 2'h0;
   wire [3:0]        n_bits    = data_bits(mode);
   // power off is an asynchronous reset of the unit apart from mode, transmit buffer, pin flops and read data
   wire              unit_rst_n = rst_n & power;
   // base clock enable; held off while power is off
   wire              base_tick = div_cnt == DIV_W'(serial_pkg::BASE_DIV - 1);
   wire              rx_line   = power ? in_sync : 1'b1;

   // mode register, writable at any time; software keeps its ordering
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) mode <= serial_pkg::MODE_RESET;
      else if (wr_mode) mode <= cpu.wdata;
   end

   // base clock divider
   always_ff @(posedge mclk or negedge unit_rst_n) begin
      if (!unit_rst_n) div_cnt <= '0;
      else div_cnt <= base_tick ? '0 : div_cnt + 1'b1;
   end

   // enables sampled on base clock so circuits reset in step with it
   always_ff @(posedge mclk or negedge unit_rst_n) begin
      if (!unit_rst_n) begin
         tx_en_s <= 1'b0;
         rx_en_s <= 1'b0;
      end else if (base_tick) begin
         tx_en_s <= mode[serial_pkg::TX_EN_BIT];
         rx_en_s <= mode[serial_pkg::RX_EN_BIT];
      end
   end

   // input pin crosses into mclk through two flops
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         in_meta <= 1'b1;
         in_sync <= 1'b1;
      end else begin
         in_meta <= serial_in_pin;
         in_sync <= in_meta;
      end
   end

   // transmit buffer keeps its value over power cycles
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) tx_data_buffer <= serial_pkg::BUF_RESET;
      else if (wr_txbuf) tx_data_buffer <= cpu.wdata;
   end

   // buffer plus shifter form the two-entry transmit path
   wire tx_bit_end = tx_busy && tx_sub == SUB_W'(serial_pkg::BIT_BASE_CLKS - 1);
   wire tx_frame_end = tx_bit_end && tx_left == 4'h1;
   wire tx_load = base_tick && tx_en_s && tx_buffer_full_flag && (!tx_busy || tx_frame_end);
   wire [3:0] frame_len = 4'h2 + n_bits + {3'h0, has_par} + {3'h0, mode[serial_pkg::STOP_BIT]};

   always_ff @(posedge mclk or negedge unit_rst_n) begin
      if (!unit_rst_n) tx_buffer_full_flag <= 1'b0;
      else if (!tx_en_s) tx_buffer_full_flag <= 1'b0;
      else if (wr_txbuf) tx_buffer_full_flag <= 1'b1;
      else if (tx_load) tx_buffer_full_flag <= 1'b0;
   end

   // shifter moves only on base clock ticks (the falling edge of the base clock)
   always_ff @(posedge mclk or negedge unit_rst_n) begin
      if (!unit_rst_n) begin
         tx_busy      <= 1'b0;
         tx_shift_reg <= 12'hFFF;
         tx_left      <= 4'h0;
         tx_sub       <= '0;
      end else if (base_tick) begin
         if (!tx_en_s) begin
            tx_busy <= 1'b0;
         end else if (tx_load) begin
            tx_busy      <= 1'b1;
            tx_shift_reg <= build_frame(tx_data_buffer, mode, msb_first);
            tx_left      <= frame_len;
            tx_sub       <= '0;
         end else if (tx_frame_end) begin
            tx_busy <= 1'b0;
         end else if (tx_bit_end) begin
            tx_shift_reg <= {1'b1, tx_shift_reg[11:1]};
            tx_left      <= tx_left - 4'h1;
            tx_sub       <= '0;
         end else if (tx_busy) begin
            tx_sub <= tx_sub + 1'b1;
         end
      end
   end

   // line drive; high whenever idle or unpowered
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) serial_out_pin <= 1'b1;
      else if (!power || !tx_busy) serial_out_pin <= 1'b1;
      else serial_out_pin <= tx_shift_reg[0];
   end

   // receive framing: start, data, optional parity, one stop
   wire       rx_sample = base_tick && rx_state == RX_RUN && rx_sub == SUB_W'(serial_pkg::SAMPLE_POINT);
   wire [3:0] stop_idx  = n_bits + 4'h1 + {3'h0, has_par};
   wire       rx_done   = rx_sample && rx_idx == stop_idx;
   wire       pe_now    = (par_code == 2'h2) ? ~rx_xor : (par_code == 2'h3) ? rx_xor : 1'b0;
   wire       fe_now    = ~rx_line;
   wire       err_now   = pe_now | fe_now | rx_full;
   wire [7:0] rx_lsb    = mode[serial_pkg::LEN_BIT] ? rx_shift_reg : {1'b0, rx_shift_reg[7:1]};
   wire [7:0] rx_msb    = mode[serial_pkg::LEN_BIT] ? rx_shift_reg : {rx_shift_reg[6:0], 1'b0};

   always_ff @(posedge mclk or negedge unit_rst_n) begin
      if (!unit_rst_n) begin
         rx_state     <= RX_IDLE;
         rx_sub       <= '0;
         rx_idx       <= 4'h0;
         rx_shift_reg <= serial_pkg::BUF_RESET;
         rx_xor       <= 1'b0;
      end else if (base_tick) begin
         case (rx_state)
            RX_IDLE: begin
               rx_sub <= '0;
               rx_idx <= 4'h0;
               rx_xor <= 1'b0;
               // a low line at enable counts as a start bit
               if (rx_en_s && !rx_line) rx_state <= RX_RUN;
            end
            RX_RUN: begin
               rx_sub <= rx_sub + 1'b1;
               if (!rx_en_s) begin
                  rx_state <= RX_IDLE;
               end else if (rx_sample) begin
                  rx_idx <= rx_idx + 4'h1;
                  if (rx_idx == 4'h0 && rx_line) begin
                     rx_state <= RX_IDLE;
                  end else if (rx_idx != 4'h0 && rx_idx <= n_bits) begin
                     rx_shift_reg <= msb_first ? {rx_shift_reg[6:0], rx_line} : {rx_line, rx_shift_reg[7:1]};
                     rx_xor       <= rx_xor ^ rx_line;
                  end else if (rx_idx != 4'h0 && !rx_done) begin
                     rx_xor <= rx_xor ^ rx_line;
                  end else if (rx_done) begin
                     rx_state <= RX_IDLE;
                  end
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   // receive buffer and full flag; buffer is never written by software
   always_ff @(posedge mclk or negedge unit_rst_n) begin
      if (!unit_rst_n) begin
         rx_data_buffer <= serial_pkg::BUF_RESET;
         rx_full        <= 1'b0;
      end else if (rx_done && !rx_full) begin
         rx_data_buffer <= msb_first ? rx_msb : rx_lsb;
         rx_full        <= 1'b1;
      end else if (rd_rxbuf) begin
         rx_full <= 1'b0;
      end
   end

   // error flags: a new error wins over the clearing read
   always_ff @(posedge mclk or negedge unit_rst_n) begin
      if (!unit_rst_n) begin
         parity_error_flag  <= 1'b0;
         framing_error_flag <= 1'b0;
         overrun_flag       <= 1'b0;
      end else begin
         parity_error_flag  <= (rx_done & pe_now) | (parity_error_flag & ~rd_rxerr);
         framing_error_flag <= (rx_done & fe_now) | (framing_error_flag & ~rd_rxerr);
         overrun_flag       <= (rx_done & rx_full) | (overrun_flag & ~rd_rxerr);
      end
   end

   // one-cycle interrupt pulses
   always_ff @(posedge mclk or negedge unit_rst_n) begin
      if (!unit_rst_n) begin
         cpu.rx_done_irq  <= 1'b0;
         cpu.rx_error_irq <= 1'b0;
         cpu.tx_done_irq  <= 1'b0;
      end else begin
         cpu.rx_done_irq  <= rx_done & (~err_now | route);
         cpu.rx_error_irq <= rx_done & err_now & ~route;
         cpu.tx_done_irq  <= base_tick & tx_en_s & tx_frame_end;
      end
   end

   // read data, registered one cycle after the strobe; unmapped reads zero
   wire [7:0] read_mux =
      (cpu.addr == serial_pkg::MODE_ADDR)    ? mode :
      (cpu.addr == serial_pkg::TX_BUF_ADDR)  ? tx_data_buffer :
      (cpu.addr == serial_pkg::RX_BUF_ADDR)  ? rx_data_buffer :
      (cpu.addr == serial_pkg::RX_ERR_ADDR)  ? {5'h00, parity_error_flag, framing_error_flag, overrun_flag} :
      (cpu.addr == serial_pkg::TX_STAT_ADDR) ? {6'h00, tx_buffer_full_flag, tx_busy} : 8'h00;

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) rdata_q <= 8'h00;
      else if (cpu.rd) rdata_q <= read_mux;
   end

   assign cpu.rdata = rdata_q;
endmodule

// *** src/serial_host.sv ***
// controller end: drives the register port in the order the unit needs
module serial_host (
   input  wire logic   mclk,
   input  wire logic   rst_n,
   serial_cpu_if.host  cpu,
   input  wire logic   open_req,
   input  wire logic   close_req,
   input  wire logic [4:0] frame_cfg,
   input  wire logic   send_valid,
   input  wire logic [7:0] send_data,
   output logic        send_ready,
   output logic        recv_valid,
   output logic [7:0]  recv_data,
   output logic        recv_error,
   input  wire logic   recv_ready,
   output logic        link_up
);
   typedef enum {H_OFF, H_PWR, H_ENABLE, H_WAIT_EN, H_READY, H_TXSTAT, H_TXCHK, H_RDERR, H_ERRWAIT,
                 H_RDBUF, H_BUFWAIT, H_PUSH, H_DISABLE, H_WAIT_DIS, H_POWEROFF} host_state_t;

   host_state_t state;
   logic [15:0] addr;
   logic        wr;
   logic        rd;
   logic [7:0]  wdata;
   logic [7:0]  cfg;
   logic [4:0]  wait_cnt;
   logic        rx_pending;
   logic        rx_err;
   logic        skid_v;
   logic [7:0]  skid_data;
   logic        skid_err;

   assign cpu.addr  = addr;
   assign cpu.wr    = wr;
   assign cpu.rd    = rd;
   assign cpu.wdata = wdata;

   wire push = state == H_PUSH;
   wire pop  = recv_valid & recv_ready;
   wire rx_irq = cpu.rx_done_irq | cpu.rx_error_irq;
   wire [7:0] en_bits = 8'h00 | (8'h01 << serial_pkg::TX_EN_BIT) | (8'h01 << serial_pkg::RX_EN_BIT);
   wire [7:0] pwr_bit = 8'h01 << serial_pkg::POWER_BIT;

   // sequencing of register accesses
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state <= H_OFF;
         addr <= 16'h0000;
         wr <= 1'b0;
         rd <= 1'b0;
         wdata <= 8'h00;
         cfg <= 8'h00;
         wait_cnt <= 5'h00;
         send_ready <= 1'b0;
         rx_err <= 1'b0;
         link_up <= 1'b0;
      end else begin
         wr <= 1'b0;
         rd <= 1'b0;
         send_ready <= 1'b0;
         case (state)
            H_OFF: if (open_req) begin
               // power first with both enables off
               cfg <= {3'h0, frame_cfg};
               addr <= serial_pkg::MODE_ADDR;
               wdata <= pwr_bit | {3'h0, frame_cfg};
               wr <= 1'b1;
               state <= H_PWR;
            end
            H_PWR: begin
               // read the power write back so a bad mode write shows before enabling
               rd <= 1'b1;
               state <= H_ENABLE;
            end
            H_ENABLE: begin
               wdata <= pwr_bit | en_bits | cfg;
               wr <= 1'b1;
               wait_cnt <= 5'(serial_pkg::TX_WRITE_WAIT_MCLK);
               state <= H_WAIT_EN;
            end
            H_WAIT_EN: begin
               // enables need a base clock to settle before data
               if (wait_cnt == 5'h00) state <= H_READY;
               else wait_cnt <= wait_cnt - 5'h01;
               link_up <= wait_cnt == 5'h00;
            end
            H_READY: begin
               if (close_req) begin
                  addr <= serial_pkg::MODE_ADDR;
                  wdata <= pwr_bit | cfg;
                  wr <= 1'b1;
                  wait_cnt <= 5'(serial_pkg::REENABLE_WAIT_MCLK);
                  link_up <= 1'b0;
                  state <= H_WAIT_DIS;
               end else if (rx_pending && !skid_v) begin
                  addr <= serial_pkg::RX_ERR_ADDR;
                  rd <= 1'b1;
                  state <= H_ERRWAIT;
               end else if (send_valid) begin
                  addr <= serial_pkg::TX_STAT_ADDR;
                  rd <= 1'b1;
                  state <= H_TXSTAT;
               end
            end
            H_TXSTAT: state <= H_TXCHK;
            H_TXCHK: begin
               // write only when the buffer is free; otherwise poll again
               if (!cpu.rdata[serial_pkg::TXBF_BIT]) begin
                  addr <= serial_pkg::TX_BUF_ADDR;
                  wdata <= send_data;
                  wr <= 1'b1;
                  send_ready <= 1'b1;
               end
               state <= H_READY;
            end
            H_ERRWAIT: state <= H_RDERR;
            H_RDERR: begin
               rx_err <= cpu.rdata[2:0] != 3'h0;
               addr <= serial_pkg::RX_BUF_ADDR;
               rd <= 1'b1;
               state <= H_BUFWAIT;
            end
            H_BUFWAIT: state <= H_RDBUF;
            H_RDBUF: state <= H_PUSH;
            H_PUSH: state <= H_READY;
            H_WAIT_DIS: begin
               if (wait_cnt == 5'h00) state <= H_POWEROFF;
               else wait_cnt <= wait_cnt - 5'h01;
            end
            H_POWEROFF: begin
               wdata <= cfg;
               wr <= 1'b1;
               state <= H_OFF;
            end
            default: state <= H_OFF;
         endcase
      end
   end

   // receive event latch; a new event wins over the clear
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) rx_pending <= 1'b0;
      else rx_pending <= rx_irq | (rx_pending & ~(state == H_READY && !close_req && !skid_v));
   end

   // two-entry receive buffer: head register plus skid; reads stop when full
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         recv_valid <= 1'b0;
         recv_data <= 8'h00;
         recv_error <= 1'b0;
         skid_v <= 1'b0;
         skid_data <= 8'h00;
         skid_err <= 1'b0;
      end else if (pop || !recv_valid) begin
         if (skid_v) begin
            recv_valid <= 1'b1;
            recv_data <= skid_data;
            recv_error <= skid_err;
            skid_v <= push;
            skid_data <= cpu.rdata;
            skid_err <= rx_err;
         end else begin
            recv_valid <= push;
            recv_data <= cpu.rdata;
            recv_error <= rx_err;
         end
      end else if (push) begin
         skid_v <= 1'b1;
         skid_data <= cpu.rdata;
         skid_err <= rx_err;
      end
   end
endmodule

// *** verif/serial_chk.sv ***
// assertions on the register port and line of the serial unit
module serial_chk (
   input wire logic        mclk,
   input wire logic        rst_n,
   input wire logic [15:0] addr,
   input wire logic        wr,
   input wire logic        rd,
   input wire logic [7:0]  wdata,
   input wire logic [7:0]  rdata,
   input wire logic        rx_done_irq,
   input wire logic        rx_error_irq,
   input wire logic        tx_done_irq,
   input wire logic        serial_out_pin
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mode_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // mode shadow, rebuilt from port writes so no peeking inside
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) mode_q <= serial_pkg::MODE_RESET;
      else if (wr && addr == serial_pkg::MODE_ADDR) mode_q <= wdata;
   end
   property p_rd; rd && addr == serial_pkg::MODE_ADDR |=> rdata == $past(mode_q); endproperty
   a_rd: assert property (p_rd) else $error("mode readback");
   // two cycles of slack for the forced-high path
   property p_off; !mode_q[7] && !$past(mode_q[7], 2) |-> serial_out_pin; endproperty
   a_off: assert property (p_off) else $error("line low while off");
   property p_irq; !(rx_done_irq && rx_error_irq); endproperty
   a_irq: assert property (p_irq) else $error("both rx irqs");
   property p_stop; tx_done_irq |-> serial_out_pin; endproperty
   a_stop: assert property (p_stop) else $error("line low at tx done");
   property p_bit; $fell(serial_out_pin) |-> !serial_out_pin [*8]; endproperty
   a_bit: assert property (p_bit) else $error("short low bit");
   property p_go; wr && addr == serial_pkg::TX_BUF_ADDR |-> ##[1:900] $fell(serial_out_pin); endproperty
   a_go: assert property (p_go) else $error("no start bit");
   property p_rxe; rx_done_irq |-> mode_q[5]; endproperty
   a_rxe: assert property (p_rxe) else $error("rx irq while disabled");
   property p_pwr; tx_done_irq |-> mode_q[7]; endproperty
   a_pwr: assert property (p_pwr) else $error("tx irq while off");
   c_rx: cover property (rx_done_irq);
   c_tx: cover property (tx_done_irq);
   c_off: cover property ($fell(mode_q[7]));
endmodule

// *** verif/tb_async_serial_buffers_and_mode.sv ***
// loopback bench: host and unit joined, bytes sent and received
module tb_async_serial_buffers_and_mode;
   timeunit 1ns;
   timeprecision 1ns;
   logic       mclk = 0, rst_n = 0, open_req = 0, close_req = 0, msb_first = 0;
   logic       send_valid = 0, recv_ready = 0, send_ready, recv_valid, recv_error, link_up, line;
   logic [4:0] frame_cfg = 0;
   logic [7:0] send_data = 0, recv_data, last_data = 8'h00;
   int         n_fail = 0, comparisons = 0;
   logic [7:0] exp_q[$];
   serial_cpu_if cpu ();
   serial_device serial_device_i (.mclk, .rst_n, .cpu(cpu.dev), .serial_in_pin(line), .msb_first,
      .serial_out_pin(line));
   serial_host serial_host_i (.mclk, .rst_n, .cpu(cpu.host), .open_req, .close_req, .frame_cfg, .send_valid,
      .send_data, .send_ready, .recv_valid, .recv_data, .recv_error, .recv_ready, .link_up);
   serial_chk serial_chk_i (.mclk, .rst_n, .addr(cpu.addr), .wr(cpu.wr), .rd(cpu.rd), .wdata(cpu.wdata),
      .rdata(cpu.rdata), .rx_done_irq(cpu.rx_done_irq), .rx_error_irq(cpu.rx_error_irq),
      .tx_done_irq(cpu.tx_done_irq), .serial_out_pin(line));
   always #10 mclk = ~mclk;
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected %s exp %h got %h", what, exp, got);
      end
   endtask
   task automatic test_done;
      if (n_fail == 0 && comparisons > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // random reader stalls exercise the recv_valid/recv_ready handshake of the head register
   always @(negedge mclk) recv_ready <= 1'($urandom);
   always @(posedge mclk) begin
      if (recv_valid && recv_ready) begin
         chk("recv_data", exp_q.pop_front(), recv_data);
         chk("recv_error", 8'h00, {7'h00, recv_error});
      end
   end
   initial begin
      void'($urandom(70785));
      repeat (20) @(posedge mclk);
      @(negedge mclk) rst_n = 1;
      // every parity code, both lengths, both orders, both stop counts
      for (int i = 0; i < 8; i++) begin
         @(negedge mclk);
         msb_first = i[1];
         frame_cfg = {i[1:0], i[2], i[0], 1'($urandom)};
         open_req = 1;
         @(negedge mclk) open_req = 0;
         wait (link_up);
         // back to back bytes test the buffer-to-shifter handover
         repeat (4) begin
            @(negedge mclk);
            send_data = 8'($urandom);
            // an equal byte would be a same-value refresh while the link is busy
            if (send_data == last_data) send_data = send_data ^ 8'h01;
            last_data = send_data;
            exp_q.push_back(i[2] ? send_data : (i[1] ? send_data & 8'hFE : send_data & 8'h7F));
            send_valid = 1;
            @(posedge mclk iff send_ready);
         end
         @(negedge mclk) send_valid = 0;
         wait (exp_q.size() == 0);
         @(negedge mclk) close_req = 1;
         @(negedge mclk) close_req = 0;
         wait (!link_up);
         repeat (20) @(negedge mclk);
      end
      test_done();
   end
   // cut a hang well past the expected run length
   initial begin
      repeat (60000) @(posedge mclk);
      n_fail++;
      test_done();
   end
endmodule
